/* logic/rtc_pkg.sv */
package rtc_pkg;
	// ----------------------------------------
	// bus geometry
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register indices, byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] IDX_READ_REQUEST = 8'h02;
	localparam logic [ADDR_W-1:0] IDX_EVENT_CONTROL = 8'h04;
	localparam logic [ADDR_W-1:0] IDX_IRQ_ENABLE_CLEAR = 8'h06;
	localparam logic [ADDR_W-1:0] IDX_IRQ_ENABLE_SET = 8'h07;
	localparam logic [ADDR_W-1:0] IDX_IRQ_FLAGS = 8'h08;
	localparam logic [ADDR_W-1:0] IDX_SYNC_STATUS = 8'h0a;
	localparam logic [ADDR_W-1:0] IDX_DEBUG_CONTROL = 8'h0b;
	localparam logic [ADDR_W-1:0] IDX_FREQUENCY_TRIM = 8'h0c;
	localparam logic [ADDR_W-1:0] IDX_CALENDAR_VALUE = 8'h10;
	localparam logic [ADDR_W-1:0] IDX_ALARM_ZERO_VALUE = 8'h18;

	localparam logic [ADDR_W-1:0] ADDR_CONTROL = IDX_CONTROL << 2;
	localparam logic [ADDR_W-1:0] ADDR_READ_REQUEST = IDX_READ_REQUEST << 2;
	localparam logic [ADDR_W-1:0] ADDR_EVENT_CONTROL = IDX_EVENT_CONTROL << 2;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE_CLEAR = IDX_IRQ_ENABLE_CLEAR << 2;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE_SET = IDX_IRQ_ENABLE_SET << 2;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAGS = IDX_IRQ_FLAGS << 2;
	localparam logic [ADDR_W-1:0] ADDR_SYNC_STATUS = IDX_SYNC_STATUS << 2;
	localparam logic [ADDR_W-1:0] ADDR_DEBUG_CONTROL = IDX_DEBUG_CONTROL << 2;
	localparam logic [ADDR_W-1:0] ADDR_FREQUENCY_TRIM = IDX_FREQUENCY_TRIM << 2;
	localparam logic [ADDR_W-1:0] ADDR_CALENDAR_VALUE = IDX_CALENDAR_VALUE << 2;
	localparam logic [ADDR_W-1:0] ADDR_ALARM_ZERO_VALUE = IDX_ALARM_ZERO_VALUE << 2;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTL_SOFT_RESET = 0;
	localparam int CTL_ENABLE = 1;
	localparam int CTL_MODE_LO = 2;
	localparam int CTL_HOUR_FORMAT = 6;
	localparam int CTL_CLEAR_ON_MATCH = 7;
	localparam int CTL_PRESC_LO = 8;
	localparam int PRESC_W = 4;
	localparam logic [1:0] MODE_CALENDAR = 2'h2;
	localparam logic [PRESC_W-1:0] PRESC_DIVIDE_BY_MAX = 4'h9;

	localparam int FLG_ALARM_MATCH = 0;
	localparam int FLG_SYNC_DONE = 6;
	localparam int FLG_OVERFLOW = 7;
	localparam int STAT_SYNC_PENDING = 7;
	localparam int DBG_RUN_WHILE_HALTED = 0;
	localparam int EV_ALARM = 8;
	localparam int EV_OVERFLOW = 15;
	localparam int PERIODIC_EV_N = 8;

	// calendar packing from bit 0 upward
	localparam int CAL_SEC_LO = 0;
	localparam int CAL_MIN_LO = 6;
	localparam int CAL_HOUR_LO = 12;
	localparam int CAL_DAY_LO = 17;
	localparam int CAL_MON_LO = 22;
	localparam int CAL_YEAR_LO = 26;
	localparam logic [5:0] SEC_MAX = 6'h3b;
	localparam logic [5:0] MIN_MAX = 6'h3b;
	localparam logic [4:0] HOUR_MAX = 5'h17;
	localparam logic [3:0] MON_MAX = 4'hc;
	localparam logic [4:0] DAYS_LONG = 5'h1f;
	localparam logic [4:0] DAYS_SHORT = 5'h1e;
	localparam logic [4:0] DAYS_FEB_LEAP = 5'h1d;
	localparam logic [4:0] DAYS_FEB = 5'h1c;

	// ----------------------------------------
	// reset values and timing
	// ----------------------------------------
	localparam logic [31:0] CAL_RESET = 32'h0042_0000;
	localparam logic [1:0] SYNC_CORE_EDGES = 2'h2;

	// pending cross-domain update
	typedef enum logic [4:0] {
		SEL_NONE = 5'b00001,
		SEL_CTRL = 5'b00010,
		SEL_CAL = 5'b00100,
		SEL_ALARM = 5'b01000,
		SEL_SRST = 5'b10000
	} sync_sel_type;
endpackage

/* logic/rtc_prescaler.sv */
`timescale 1ns/1ps
module rtc_prescaler #(
	parameter int STAGES = 10
) (
	input wire logic i_mclk,
	input wire logic i_clr,
	input wire logic i_step,
	input wire logic [3:0] i_div_sel,
	output logic o_tick,
	output logic [STAGES-1:0] o_count
);
	logic [STAGES-1:0] count_q;
	logic [STAGES-1:0] mask;

	// free count of core edges while running
	always_ff @(posedge i_mclk) begin
		if (i_clr) begin
			count_q <= '0;
		end else if (i_step) begin
			count_q <= count_q + 1'b1;
		end
	end

	// tick on every 2^n-th step
	always_comb begin
		mask = (STAGES'(1) << i_div_sel) - 1'b1;
		o_tick = i_step & ((count_q & mask) == mask);
		o_count = count_q;
	end
endmodule

/* logic/rtc_calendar_timer.sv */
// Notes on behaviour
// - synchronise writes into the core domain
// - debug halt stops counting by default
// - run_while_halted keeps counting under halt
// - one combined interrupt request output
// - event outputs drive the event router
// - write protect blocks all but flags
// - flags W1C, enable set/clear registers
// - soft reset discards rest of write
// - soft reset and pending read one
// - soft reset ignores enable protection
// - prescaler divides by two to n
// - prescaler written directly, no handshake
// - calendar and alarm share one packing
// - only power-on or soft reset clears
// - keeps running in sleep, irq wakes
`timescale 1ns/1ps
module rtc_calendar_timer (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic [rtc_pkg::ADDR_W-1:0] i_addr,
	input wire logic [rtc_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [rtc_pkg::DATA_W-1:0] o_rdata,
	input wire logic i_core_timebase_clock,
	input wire logic i_dbg_halt,
	input wire logic i_wr_protect,
	output logic o_irq,
	output logic [rtc_pkg::PERIODIC_EV_N-1:0] o_periodic_evt,
	output logic o_alarm_evt,
	output logic o_overflow_evt
);
	import rtc_pkg::*;

	// ----------------------------------------
	// core timebase synchroniser
	// ----------------------------------------
	logic core_meta_q;
	logic core_sync_q;
	logic core_prev_q;
	logic core_tick;

	// two flops, then edge detect on the second
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			core_meta_q <= 1'b0;
			core_sync_q <= 1'b0;
			core_prev_q <= 1'b0;
		end else begin
			core_meta_q <= i_core_timebase_clock;
			core_sync_q <= core_meta_q;
			core_prev_q <= core_sync_q;
		end
	end
	// no edges, no counting
	assign core_tick = core_sync_q & ~core_prev_q;

	// ----------------------------------------
	// state and decode
	// ----------------------------------------
	sync_sel_type sel_q;
	logic [1:0] sync_cnt_q;
	logic [DATA_W-1:0] pend_q;
	logic enable_q;
	logic [1:0] mode_q;
	logic hour_format_q;
	logic clear_on_match_q;
	logic [PRESC_W-1:0] presc_q;
	logic [15:0] read_req_q;
	logic [15:0] ev_ctrl_q;
	logic [7:0] irq_en_q;
	logic [7:0] flags_q;
	logic run_while_halted_q;
	logic [7:0] trim_q;
	logic [31:0] cal_q;
	logic [31:0] alarm_q;
	logic busy;
	logic sync_fire;
	logic srst_fire;
	logic clr;
	logic wr_ok;
	logic run;
	logic step;
	logic cnt_tick;
	logic [9:0] presc_count;
	logic [32:0] cal_next;
	logic match;
	logic wrap;
	logic [PERIODIC_EV_N-1:0] per_hit;

	assign busy = (sel_q != SEL_NONE);
	assign sync_fire = busy & core_tick & (sync_cnt_q == SYNC_CORE_EDGES - 2'h1);
	assign srst_fire = sync_fire & (sel_q == SEL_SRST);
	// power-on or soft reset only
	assign clr = ~i_nrst | srst_fire;
	// write protect gate for all but flags
	assign wr_ok = i_wr & ~i_wr_protect;
	// halt stops count unless run_while_halted
	assign run = enable_q & (mode_q == MODE_CALENDAR) & (~i_dbg_halt | run_while_halted_q);
	assign step = core_tick & run;

	// counter tick divider
	rtc_prescaler #(.STAGES(10)) u_prescaler (
		.i_mclk(i_mclk),
		.i_clr(clr),
		.i_step(step),
		.i_div_sel(presc_q),
		.o_tick(cnt_tick),
		.o_count(presc_count)
	);

	// ----------------------------------------
	// calendar arithmetic
	// ----------------------------------------
	// one second step with carries, year wrap as top bit
	function automatic logic [32:0] cal_step(input logic [31:0] v);
		logic [5:0] sec;
		logic [5:0] min;
		logic [4:0] hr;
		logic [4:0] day;
		logic [3:0] mon;
		logic [5:0] yr;
		logic [4:0] dmax;
		logic ovf;
		logic cy_s, cy_m, cy_h, cy_d, cy_o;
		sec = v[CAL_SEC_LO +: 6];
		min = v[CAL_MIN_LO +: 6];
		hr = v[CAL_HOUR_LO +: 5];
		day = v[CAL_DAY_LO +: 5];
		mon = v[CAL_MON_LO +: 4];
		yr = v[CAL_YEAR_LO +: 6];
		case (mon)
			4'h2: dmax = (yr[1:0] == 2'h0) ? DAYS_FEB_LEAP : DAYS_FEB;
			4'h4, 4'h6, 4'h9, 4'hb: dmax = DAYS_SHORT;
			default: dmax = DAYS_LONG;
		endcase
		cy_s = (sec >= SEC_MAX);
		cy_m = cy_s & (min >= MIN_MAX);
		cy_h = cy_m & (hr >= HOUR_MAX);
		cy_d = cy_h & (day >= dmax);
		cy_o = cy_d & (mon >= MON_MAX);
		sec = cy_s ? 6'h00 : sec + 6'h01;
		min = cy_m ? 6'h00 : min + {5'h00, cy_s};
		hr = cy_h ? 5'h00 : hr + {4'h0, cy_m};
		day = cy_d ? 5'h01 : day + {4'h0, cy_h};
		mon = cy_o ? 4'h1 : mon + {3'h0, cy_d};
		{ovf, yr} = {1'b0, yr} + {6'h00, cy_o};
		// shared packing for clock and alarm
		return {ovf, yr, mon, day, hr, min, sec};
	endfunction

	// next value, match and wrap on counter tick
	always_comb begin
		cal_next = cal_step(cal_q);
		match = cnt_tick & (cal_next[31:0] == alarm_q);
		wrap = cnt_tick & cal_next[32];
	end

	// periodic hits from prescaler stages
	for (genvar n = 0; n < PERIODIC_EV_N; n++) begin : g_per
		assign per_hit[n] = step & (&presc_count[n:0]);
	end

	// ----------------------------------------
	// cross-domain write slot
	// ----------------------------------------
	// soft reset accepted even when enabled, rest discarded
	always_ff @(posedge i_mclk) begin
		if (clr) begin
			sel_q <= SEL_NONE;
			sync_cnt_q <= 2'h0;
			pend_q <= '0;
		end else if (wr_ok && i_addr == ADDR_CONTROL && i_wdata[CTL_SOFT_RESET]
			&& sel_q != SEL_SRST) begin
			sel_q <= SEL_SRST;
			sync_cnt_q <= 2'h0;
		end else if (wr_ok && !busy && i_addr == ADDR_CONTROL) begin
			sel_q <= SEL_CTRL;
			sync_cnt_q <= 2'h0;
			pend_q <= i_wdata;
		end else if (wr_ok && !busy && i_addr == ADDR_CALENDAR_VALUE) begin
			sel_q <= SEL_CAL;
			sync_cnt_q <= 2'h0;
			pend_q <= i_wdata;
		end else if (wr_ok && !busy && i_addr == ADDR_ALARM_ZERO_VALUE) begin
			sel_q <= SEL_ALARM;
			sync_cnt_q <= 2'h0;
			pend_q <= i_wdata;
		end else if (sync_fire) begin
			sel_q <= SEL_NONE;
			sync_cnt_q <= 2'h0;
		end else if (busy && core_tick) begin
			sync_cnt_q <= sync_cnt_q + 2'h1;
		end
	end

	// ----------------------------------------
	// control fields
	// ----------------------------------------
	// synchronised fields, mode and options only while disabled
	always_ff @(posedge i_mclk) begin
		if (clr) begin
			enable_q <= 1'b0;
			mode_q <= 2'h0;
			hour_format_q <= 1'b0;
			clear_on_match_q <= 1'b0;
		end else if (sync_fire && sel_q == SEL_CTRL) begin
			enable_q <= pend_q[CTL_ENABLE];
			if (!enable_q) begin
				mode_q <= pend_q[CTL_MODE_LO +: 2];
				hour_format_q <= pend_q[CTL_HOUR_FORMAT];
				clear_on_match_q <= pend_q[CTL_CLEAR_ON_MATCH];
			end
		end
	end

	// prescaler taken at once, no handshake
	always_ff @(posedge i_mclk) begin
		if (clr) begin
			presc_q <= '0;
		end else if (wr_ok && i_addr == ADDR_CONTROL && !i_wdata[CTL_SOFT_RESET]
			&& !busy && !enable_q) begin
			if (i_wdata[CTL_PRESC_LO +: PRESC_W] <= PRESC_DIVIDE_BY_MAX) begin
				presc_q <= i_wdata[CTL_PRESC_LO +: PRESC_W];
			end else begin
				presc_q <= PRESC_DIVIDE_BY_MAX;
			end
		end
	end

	// plain configuration registers
	always_ff @(posedge i_mclk) begin
		if (clr) begin
			read_req_q <= '0;
			ev_ctrl_q <= '0;
			run_while_halted_q <= 1'b0;
			trim_q <= '0;
		end else if (wr_ok) begin
			if (i_addr == ADDR_READ_REQUEST) begin
				read_req_q <= i_wdata[15:0];
			end
			if (i_addr == ADDR_EVENT_CONTROL) begin
				ev_ctrl_q <= i_wdata[15:0];
			end
			if (i_addr == ADDR_DEBUG_CONTROL) begin
				run_while_halted_q <= i_wdata[DBG_RUN_WHILE_HALTED];
			end
			if (i_addr == ADDR_FREQUENCY_TRIM) begin
				trim_q <= i_wdata[7:0];
			end
		end
	end

	// interrupt enables through set and clear views
	always_ff @(posedge i_mclk) begin
		if (clr) begin
			irq_en_q <= '0;
		end else if (wr_ok && i_addr == ADDR_IRQ_ENABLE_SET) begin
			irq_en_q <= irq_en_q | i_wdata[7:0];
		end else if (wr_ok && i_addr == ADDR_IRQ_ENABLE_CLEAR) begin
			irq_en_q <= irq_en_q & ~i_wdata[7:0];
		end
	end

	// ----------------------------------------
	// calendar and alarm
	// ----------------------------------------
	// software update wins over a tick in the same cycle
	always_ff @(posedge i_mclk) begin
		if (clr) begin
			cal_q <= CAL_RESET;
		end else if (sync_fire && sel_q == SEL_CAL) begin
			cal_q <= pend_q;
		end else if (match && clear_on_match_q) begin
			cal_q <= CAL_RESET;
		end else if (cnt_tick) begin
			cal_q <= cal_next[31:0];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (clr) begin
			alarm_q <= CAL_RESET;
		end else if (sync_fire && sel_q == SEL_ALARM) begin
			alarm_q <= pend_q;
		end
	end

	// ----------------------------------------
	// flags and interrupt
	// ----------------------------------------
	// write one clears, a set in the same cycle wins, never protected
	always_ff @(posedge i_mclk) begin
		if (clr) begin
			flags_q <= '0;
		end else begin
			if (i_wr && i_addr == ADDR_IRQ_FLAGS) begin
				flags_q <= flags_q & ~i_wdata[7:0];
			end
			if (match) begin
				flags_q[FLG_ALARM_MATCH] <= 1'b1;
			end
			if (wrap) begin
				flags_q[FLG_OVERFLOW] <= 1'b1;
			end
			if (sync_fire && sel_q != SEL_SRST) begin
				flags_q[FLG_SYNC_DONE] <= 1'b1;
			end
		end
	end

	// one combined request, not gated by sleep
	always_ff @(posedge i_mclk) begin
		if (clr) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(flags_q & irq_en_q);
		end
	end

	// event pulses toward the router
	always_ff @(posedge i_mclk) begin
		if (clr) begin
			o_periodic_evt <= '0;
			o_alarm_evt <= 1'b0;
			o_overflow_evt <= 1'b0;
		end else begin
			o_periodic_evt <= per_hit & ev_ctrl_q[PERIODIC_EV_N-1:0];
			o_alarm_evt <= match & ev_ctrl_q[EV_ALARM];
			o_overflow_evt <= wrap & ev_ctrl_q[EV_OVERFLOW];
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	// data only in the cycle after the strobe, unmapped reads zero
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_rdata <= '0;
		end else if (i_rd) begin
			case (i_addr)
				ADDR_CONTROL: o_rdata <= {16'h0000, 4'h0, presc_q, clear_on_match_q,
					hour_format_q, 2'h0, mode_q, enable_q, sel_q == SEL_SRST};
				ADDR_READ_REQUEST: o_rdata <= {16'h0000, read_req_q};
				ADDR_EVENT_CONTROL: o_rdata <= {16'h0000, ev_ctrl_q};
				ADDR_IRQ_ENABLE_CLEAR: o_rdata <= {24'h00_0000, irq_en_q};
				ADDR_IRQ_ENABLE_SET: o_rdata <= {24'h00_0000, irq_en_q};
				ADDR_IRQ_FLAGS: o_rdata <= {24'h00_0000, flags_q};
				ADDR_SYNC_STATUS: o_rdata <= {24'h00_0000, busy, 7'h00};
				ADDR_DEBUG_CONTROL: o_rdata <= {31'h0000_0000, run_while_halted_q};
				ADDR_FREQUENCY_TRIM: o_rdata <= {24'h00_0000, trim_q};
				ADDR_CALENDAR_VALUE: o_rdata <= cal_q;
				ADDR_ALARM_ZERO_VALUE: o_rdata <= alarm_q;
				default: o_rdata <= '0;
			endcase
		end else begin
			o_rdata <= '0;
		end
	end
endmodule

/* verif/rtc_timebase_source.sv */
`timescale 1ns/1ps
module rtc_timebase_source #(
	parameter realtime HALF_NS = 20.0
) (
	input wire logic i_run,
	output logic o_clk
);
	// ----
	// dedicated core timebase
	// ----
	initial o_clk = 1'b0;
	// free-running, started at time zero, before any use
	// private source, never the shared system generator
	always begin
		#(HALF_NS);
		if (i_run) begin
			o_clk = ~o_clk;
		end
	end
endmodule

/* verif/rtc_calendar_timer_asserts.sv */
`timescale 1ns/1ps
module rtc_calendar_timer_asserts (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic [rtc_pkg::ADDR_W-1:0] i_addr,
	input wire logic i_rd,
	input wire logic [rtc_pkg::DATA_W-1:0] o_rdata,
	input wire logic o_irq,
	input wire logic [rtc_pkg::PERIODIC_EV_N-1:0] o_periodic_evt,
	input wire logic o_alarm_evt,
	input wire logic o_overflow_evt
);
	import rtc_pkg::*;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_nrst);
	// ----
	// read of one register
	// ----
	sequence s_rd(logic [7:0] a);
		i_rd && i_addr == a;
	endsequence
	// ----
	// bus answers
	// ----
	a_rdata_idle: assert property (!i_rd |=> o_rdata == '0)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (i_rd && i_addr[1:0] != 2'h0 |=> o_rdata == '0)
		else $error("unmapped read not zero");
	a_status_busy_only: assert property (s_rd(ADDR_SYNC_STATUS) |=> (o_rdata & ~32'h0000_0080) == '0)
		else $error("status shows bits other than pending");
	a_flags_three_bits: assert property (s_rd(ADDR_IRQ_FLAGS) |=> (o_rdata & ~32'h0000_00c1) == '0)
		else $error("flags show undefined bits");
	a_debug_one_bit: assert property (s_rd(ADDR_DEBUG_CONTROL) |=> o_rdata[31:1] == '0)
		else $error("debug control shows undefined bits");
	a_presc_range: assert property (s_rd(ADDR_CONTROL) |=>
		o_rdata[11:8] <= PRESC_DIVIDE_BY_MAX && o_rdata[31:12] == '0)
		else $error("prescaler field out of range");
	// ----
	// outputs after reset and event pulses
	// ----
	a_release_quiet: assert property ($rose(i_nrst) |-> !o_irq && o_rdata == '0 && !o_alarm_evt
		&& !o_overflow_evt && o_periodic_evt == '0)
		else $error("outputs active after reset");
	a_alarm_pulse: assert property (o_alarm_evt |=> !o_alarm_evt)
		else $error("alarm event longer than one cycle");
	a_ovf_pulse: assert property (o_overflow_evt |=> !o_overflow_evt [*8])
		else $error("overflow event repeated");
endmodule
bind rtc_calendar_timer rtc_calendar_timer_asserts rtc_calendar_timer_asserts_inst (
	.i_mclk(i_mclk),
	.i_nrst(i_nrst),
	.i_addr(i_addr),
	.i_rd(i_rd),
	.o_rdata(o_rdata),
	.o_irq(o_irq),
	.o_periodic_evt(o_periodic_evt),
	.o_alarm_evt(o_alarm_evt),
	.o_overflow_evt(o_overflow_evt)
);

/* verif/rtc_calendar_timer_tb.sv */
`timescale 1ns/1ps
module rtc_calendar_timer_tb;
	import rtc_pkg::*;
	localparam int LIMIT = 20000;
	logic i_mclk;
	logic i_nrst;
	logic [ADDR_W-1:0] i_addr;
	logic [DATA_W-1:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic [DATA_W-1:0] o_rdata;
	logic core_clk;
	logic i_dbg_halt;
	logic i_wr_protect;
	logic o_irq;
	logic [PERIODIC_EV_N-1:0] o_periodic_evt;
	logic o_alarm_evt;
	logic o_overflow_evt;
	logic alarm_seen;
	logic ovf_seen;
	logic [PERIODIC_EV_N-1:0] per_seen;
	logic [31:0] a;
	logic [31:0] d;
	int num_errors;
	int check_count;
	int cycles;
	rtc_calendar_timer rtc_calendar_timer_inst (
		.i_mclk(i_mclk),
		.i_nrst(i_nrst),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.o_rdata(o_rdata),
		.i_core_timebase_clock(core_clk),
		.i_dbg_halt(i_dbg_halt),
		.i_wr_protect(i_wr_protect),
		.o_irq(o_irq),
		.o_periodic_evt(o_periodic_evt),
		.o_alarm_evt(o_alarm_evt),
		.o_overflow_evt(o_overflow_evt)
	);
	rtc_timebase_source rtc_timebase_source_inst (
		.i_run(1'b1),
		.o_clk(core_clk)
	);
	// ----
	// clock, ceiling, event capture
	// ----
	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (o_alarm_evt === 1'b1) begin
			alarm_seen <= 1'b1;
		end
		if (o_overflow_evt === 1'b1) begin
			ovf_seen <= 1'b1;
		end
		if (i_nrst === 1'b1) begin
			per_seen <= per_seen | o_periodic_evt;
		end
		if (cycles == LIMIT) begin
			num_errors++;
			tally_and_finish();
		end
	end
	// ----
	// bus tasks
	// ----
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] v);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= ad;
		i_wdata <= v;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [31:0] v);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= ad;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		@(negedge i_mclk);
		v = o_rdata;
	endtask
	task automatic rdchk(input string name, input logic [7:0] ad, input logic [31:0] exp);
		logic [31:0] v;
		rd(ad, v);
		check(name, v, exp);
	endtask
	// poll pending bit, bounded
	task automatic wait_sync();
		logic [31:0] v;
		int n;
		v = 32'h0000_0080;
		for (n = 0; n < 100 && v[STAT_SYNC_PENDING] !== 1'b0; n++) begin
			rd(ADDR_SYNC_STATUS, v);
		end
		check("sync_wait", v, 32'h0000_0000);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	initial begin
		logic [7:0] ra [9];
		logic [31:0] rv [9];
		i_nrst = 1'b0;
		i_addr = '0;
		i_wdata = '0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_dbg_halt = 1'b0;
		i_wr_protect = 1'b0;
		alarm_seen = 1'b0;
		ovf_seen = 1'b0;
		per_seen = '0;
		num_errors = 0;
		check_count = 0;
		cycles = 0;
		repeat (20) @(posedge i_mclk);
		i_nrst <= 1'b1;
		// reset values, unmapped address last
		ra = '{ADDR_CONTROL, ADDR_EVENT_CONTROL, ADDR_IRQ_ENABLE_SET, ADDR_IRQ_FLAGS,
			ADDR_SYNC_STATUS, ADDR_DEBUG_CONTROL, ADDR_CALENDAR_VALUE, ADDR_ALARM_ZERO_VALUE, 8'h04};
		rv = '{default: '0};
		rv[6] = CAL_RESET;
		rv[7] = CAL_RESET;
		for (int i = 0; i < 9; i++) begin
			rdchk("reset_value", ra[i], rv[i]);
		end
		// prescaler lands at once, no handshake
		wr(ADDR_CONTROL, 32'h0000_0900);
		rdchk("prescaler", ADDR_CONTROL, 32'h0000_0900);
		wait_sync();
		// flags clear by one, sync done sets
		wr(ADDR_IRQ_FLAGS, 32'h0000_00ff);
		rdchk("flags_clear", ADDR_IRQ_FLAGS, 32'h0000_0000);
		wr(ADDR_ALARM_ZERO_VALUE, 32'h0042_0001);
		rdchk("pending", ADDR_SYNC_STATUS, 32'h0000_0080);
		wait_sync();
		rdchk("alarm", ADDR_ALARM_ZERO_VALUE, 32'h0042_0001);
		rdchk("sync_done", ADDR_IRQ_FLAGS, 32'h0000_0040);
		// enables and interrupt line
		wr(ADDR_IRQ_ENABLE_SET, 32'h0000_00c1);
		rdchk("enable_mirror", ADDR_IRQ_ENABLE_CLEAR, 32'h0000_00c1);
		repeat (2) @(negedge i_mclk);
		check("irq_on", {31'h0, o_irq}, 32'h0000_0001);
		// write protection spares only the flags
		@(posedge i_mclk);
		i_wr_protect <= 1'b1;
		wr(ADDR_IRQ_ENABLE_CLEAR, 32'h0000_00ff);
		rdchk("wp_enable", ADDR_IRQ_ENABLE_SET, 32'h0000_00c1);
		wr(ADDR_DEBUG_CONTROL, 32'h0000_0001);
		rdchk("wp_debug", ADDR_DEBUG_CONTROL, 32'h0000_0000);
		wr(ADDR_IRQ_FLAGS, 32'h0000_00ff);
		rdchk("wp_flags", ADDR_IRQ_FLAGS, 32'h0000_0000);
		repeat (2) @(negedge i_mclk);
		check("irq_off", {31'h0, o_irq}, 32'h0000_0000);
		@(posedge i_mclk);
		i_wr_protect <= 1'b0;
		// two seconds before the end of year 63, wrap then alarm match
		wr(ADDR_EVENT_CONTROL, 32'h0000_8101);
		wr(ADDR_CALENDAR_VALUE, 32'hff3f_7efa);
		wait_sync();
		wr(ADDR_CONTROL, 32'h0000_000a);
		wait_sync();
		repeat (40) @(posedge i_mclk);
		rdchk("wrap_flags", ADDR_IRQ_FLAGS, 32'h0000_00c1);
		check("alarm_evt", {31'h0, alarm_seen}, 32'h0000_0001);
		check("ovf_evt", {31'h0, ovf_seen}, 32'h0000_0001);
		check("per_evt", {24'h00_0000, per_seen}, 32'h0000_0001);
		// debug halt freezes, run_while_halted resumes
		@(posedge i_mclk);
		i_dbg_halt <= 1'b1;
		repeat (10) @(posedge i_mclk);
		rd(ADDR_CALENDAR_VALUE, a);
		repeat (50) @(posedge i_mclk);
		rdchk("halted", ADDR_CALENDAR_VALUE, a);
		wr(ADDR_DEBUG_CONTROL, 32'h0000_0001);
		repeat (50) @(posedge i_mclk);
		rd(ADDR_CALENDAR_VALUE, d);
		check("run_halted", {31'h0, d !== a}, 32'h0000_0001);
		@(posedge i_mclk);
		i_dbg_halt <= 1'b0;
		// soft reset while enabled, other fields dropped
		wr(ADDR_CONTROL, 32'h0000_0005);
		rd(ADDR_CONTROL, d);
		check("srst_bit", {31'h0, d[CTL_SOFT_RESET]}, 32'h0000_0001);
		rdchk("srst_pending", ADDR_SYNC_STATUS, 32'h0000_0080);
		wait_sync();
		rdchk("srst_ctrl", ADDR_CONTROL, 32'h0000_0000);
		rdchk("srst_cal", ADDR_CALENDAR_VALUE, CAL_RESET);
		rdchk("srst_flags", ADDR_IRQ_FLAGS, 32'h0000_0000);
		rdchk("srst_debug", ADDR_DEBUG_CONTROL, 32'h0000_0000);
		tally_and_finish();
	end
endmodule
